// ### src/sdram_pkg.sv
// shared constants and types for the synchronous dram module core
// =====================================================================
package sdram_pkg;

   // =====================================================================
   // geometry
   localparam int ROW_W = 13;
   localparam int COL_W = 10;
   localparam int BANK_W = 2;
   localparam int NBANK = 4;
   localparam int LANE_W = 16;
   localparam int NLANE = 4;
   localparam int DQ_W = LANE_W * NLANE;
   localparam int DQM_W = DQ_W / 8;

   // =====================================================================
   // commands as {ras_n, cas_n, we_n}
   localparam logic [2:0] CMD_LMR = 3'h0;
   localparam logic [2:0] CMD_REF = 3'h1;
   localparam logic [2:0] CMD_PRE = 3'h2;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_WR = 3'h4;
   localparam logic [2:0] CMD_RD = 3'h5;
   localparam logic [2:0] CMD_BST = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;

   // =====================================================================
   // address and mode fields
   localparam int AP_BIT = 10;
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_BT_BIT = 3;
   localparam int MODE_CL_LSB = 4;
   localparam int MODE_WB_BIT = 9;
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] CL_3 = 3'h3;
   localparam logic [ROW_W-1:0] MODE_RST = 13'h0000;
   localparam logic [COL_W-1:0] LAST_1 = 10'h000;
   localparam logic [COL_W-1:0] LAST_2 = 10'h001;
   localparam logic [COL_W-1:0] LAST_4 = 10'h003;
   localparam logic [COL_W-1:0] LAST_8 = 10'h007;
   localparam logic [COL_W-1:0] LAST_FULL = 10'h3ff;

   // =====================================================================
   // timing at the system clock rate
   localparam int CLK_MHZ = 50;
   localparam int PWRUP_US = 100;
   localparam int PWRUP_CYC = PWRUP_US * CLK_MHZ;
   localparam int WAIT_W = 16;
   localparam int TRP_NS = 20;
   localparam int TRP_CYC_I = (TRP_NS * CLK_MHZ + 999) / 1000;
   localparam int PRE_W = 3;
   localparam logic [PRE_W-1:0] TRP_CYC = PRE_W'((TRP_CYC_I < 1) ? 1 : TRP_CYC_I);

   // =====================================================================
   // power-up progress, gray coded along the init path
   typedef enum logic [2:0] {
      IS_WAIT = 3'h0,
      IS_PRECH = 3'h1,
      IS_REF1 = 3'h3,
      IS_REF2 = 3'h2,
      IS_READY = 3'h6
   } init_state_t;

endpackage

// ### src/out_buf.sv
// two-entry buffer between the read array and the data pins
module out_buf #(
   parameter int W = 64 // word width
) (
   input wire logic clk_i,            // system clock
   input wire logic sys_rst_i,        // async reset, active high
   input wire logic in_valid_i,       // word offered
   output logic in_ready_o,           // room for a word
   input wire logic [W-1:0] in_data_i, // offered word
   output logic out_valid_o,          // head word present
   input wire logic out_ready_i,      // head word taken
   output logic [W-1:0] out_data_o    // head word, registered
);

   logic [W-1:0] d0_r;
   logic [W-1:0] d1_r;
   logic [W-1:0] d0_nxt;
   logic [W-1:0] d1_nxt;
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_r != 2'h2);
   assign out_valid_o = (cnt_r != 2'h0);
   assign out_data_o = d0_r;

   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      d0_nxt = d0_r;
      d1_nxt = d1_r;
      cnt_nxt = cnt_r;
      case ({push, pop})
         2'b10: begin
            if (cnt_r == 2'h0) begin
               d0_nxt = in_data_i;
            end else begin
               d1_nxt = in_data_i;
            end
            cnt_nxt = cnt_r + 2'h1;
         end
         2'b01: begin
            d0_nxt = d1_r;
            cnt_nxt = cnt_r - 2'h1;
         end
         2'b11: begin
            if (cnt_r == 2'h1) begin
               d0_nxt = in_data_i;
            end else begin
               d0_nxt = d1_r;
               d1_nxt = in_data_i;
            end
         end
         default: begin
            cnt_nxt = cnt_r;
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         d0_r <= '0;
         d1_r <= '0;
         cnt_r <= 2'h0;
      end else begin
         d0_r <= d0_nxt;
         d1_r <= d1_nxt;
         cnt_r <= cnt_nxt;
      end
   end

endmodule

// ### src/sdram_core.sv
// command decoder, bank tracker, burst engine and storage of the dram module
module sdram_core
   import sdram_pkg::*;
#(
   parameter int PWRUP_CYCLES = PWRUP_CYC, // power-up settle count
   parameter int STORE_AW = 12             // address bits kept by the backing arrays
) (
   input wire logic clk_i,                // 50 MHz system clock
   input wire logic sys_rst_i,            // async reset, active high
   input wire logic cke_i,                // clock enable
   input wire logic cs_n_i,               // chip select, active low
   input wire logic ras_n_i,              // row strobe, active low
   input wire logic cas_n_i,              // column strobe, active low
   input wire logic we_n_i,               // write enable, active low
   input wire logic bank_select_low_i,    // bank select bit 0
   input wire logic bank_select_high_i,   // bank select bit 1
   input wire logic [ROW_W-1:0] addr_i,   // row or column address and mode value
   input wire logic [DQM_W-1:0] dqm_i,    // per byte data mask
   input wire logic [DQ_W-1:0] dq_i,      // data pins, input side
   output logic [DQ_W-1:0] dq_o,          // data pins, output side
   output logic [DQM_W-1:0] dq_oe_o       // per byte drive enable
);

   // =====================================================================
   // command decode
   logic [2:0] cmd;
   logic [BANK_W-1:0] cmd_bank;
   logic [ROW_W-1:0] row_address_lines;
   logic [COL_W-1:0] column_address_lines;
   logic [NBANK-1:0] bank_open;
   logic [NBANK-1:0] bank_pre_busy;
   logic [ROW_W-1:0] bank_row [NBANK];
   logic all_idle;
   init_state_t init_r;
   init_state_t init_nxt;
   logic pre_take;
   logic ref_take;
   logic lmr_take;
   logic act_take;
   logic rd_take;
   logic wr_take;
   logic bst_take;
   logic bst_act_r;

   // a low clock enable freezes the command path as well as the burst
   assign cmd = (cs_n_i || !cke_i) ? CMD_NOP : {ras_n_i, cas_n_i, we_n_i};
   assign cmd_bank = {bank_select_high_i, bank_select_low_i};
   assign row_address_lines = addr_i;
   assign column_address_lines = addr_i[COL_W-1:0];
   assign all_idle = (bank_open == '0) && (bank_pre_busy == '0);

   // =====================================================================
   // power-up progress and mode register
   logic [WAIT_W-1:0] wait_r;
   logic [WAIT_W-1:0] wait_nxt;
   logic wait_done;
   logic [ROW_W-1:0] mode_r;
   logic [ROW_W-1:0] mode_nxt;
   logic [ROW_W-1:0] ref_row_r;
   logic [ROW_W-1:0] ref_row_nxt;

   assign wait_done = (wait_r == WAIT_W'(PWRUP_CYCLES));
   assign pre_take = wait_done && (cmd == CMD_PRE);
   assign ref_take = (init_r != IS_WAIT) && all_idle && (cmd == CMD_REF);
   assign lmr_take = ((init_r == IS_REF2) || (init_r == IS_READY)) && all_idle && (cmd == CMD_LMR);
   // only the first precharge-all after the wait, two refreshes and a loaded mode open the array
   assign act_take = (init_r == IS_READY) && (cmd == CMD_ACT) && !bank_open[cmd_bank]
                     && !bank_pre_busy[cmd_bank];
   assign rd_take = (init_r == IS_READY) && (cmd == CMD_RD) && bank_open[cmd_bank];
   assign wr_take = (init_r == IS_READY) && (cmd == CMD_WR) && bank_open[cmd_bank];
   assign bst_take = (cmd == CMD_BST) && bst_act_r;

   always_comb begin
      init_nxt = init_r;
      wait_nxt = wait_r;
      mode_nxt = mode_r;
      ref_row_nxt = ref_row_r;
      if (!wait_done) begin
         wait_nxt = wait_r + WAIT_W'(1);
      end
      if (lmr_take) begin
         mode_nxt = row_address_lines;
      end
      if (ref_take) begin
         ref_row_nxt = ref_row_r + ROW_W'(1);
      end
      case (init_r)
         IS_WAIT: if (pre_take && addr_i[AP_BIT]) init_nxt = IS_PRECH;
         IS_PRECH: if (ref_take) init_nxt = IS_REF1;
         IS_REF1: if (ref_take) init_nxt = IS_REF2;
         IS_REF2: if (lmr_take) init_nxt = IS_READY;
         IS_READY: init_nxt = IS_READY;
         default: init_nxt = IS_WAIT;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         init_r <= IS_WAIT;
         wait_r <= '0;
         mode_r <= MODE_RST;
         ref_row_r <= '0;
      end else begin
         init_r <= init_nxt;
         wait_r <= wait_nxt;
         mode_r <= mode_nxt;
         ref_row_r <= ref_row_nxt;
      end
   end

   // =====================================================================
   // burst engine
   logic bst_wr_r;
   logic bst_ap_r;
   logic bst_bt_r;
   logic lat_r;
   logic [BANK_W-1:0] bst_bank_r;
   logic [COL_W-1:0] bst_start_r;
   logic [COL_W-1:0] bst_cnt_r;
   logic [COL_W-1:0] bst_last_r;
   logic bst_act_nxt;
   logic bst_wr_nxt;
   logic bst_ap_nxt;
   logic bst_bt_nxt;
   logic lat_nxt;
   logic [BANK_W-1:0] bst_bank_nxt;
   logic [COL_W-1:0] bst_start_nxt;
   logic [COL_W-1:0] bst_cnt_nxt;
   logic [COL_W-1:0] bst_last_nxt;
   logic [COL_W-1:0] bst_off;
   logic [COL_W-1:0] bst_col;
   logic [COL_W-1:0] new_last;
   logic buf_in_valid;
   logic buf_in_ready;
   logic step;
   logic last;
   logic wr_single;
   logic ap_fire;
   logic [BANK_W-1:0] ap_bank;

   function automatic logic [COL_W-1:0] burst_last(input logic [2:0] code);
      case (code)
         BL_1: burst_last = LAST_1;
         BL_2: burst_last = LAST_2;
         BL_4: burst_last = LAST_4;
         BL_8: burst_last = LAST_8;
         BL_FULL: burst_last = LAST_FULL;
         default: burst_last = LAST_1;
      endcase
   endfunction

   // single-location write mode overrides the programmed length for writes only
   assign new_last = (wr_take && mode_r[MODE_WB_BIT]) ? LAST_1 : burst_last(mode_r[MODE_BL_LSB +: 3]);
   assign buf_in_valid = bst_act_r && !bst_wr_r && !lat_r && cke_i;
   // reads advance only when the buffer has room, so a stalled pin side loses no word
   assign step = bst_act_r && cke_i && (bst_wr_r || (!lat_r && buf_in_ready));
   assign last = (bst_cnt_r == bst_last_r);
   assign wr_single = wr_take && (new_last == LAST_1);
   assign ap_fire = (step && last && bst_ap_r) || (wr_single && addr_i[AP_BIT]);
   assign ap_bank = wr_single ? cmd_bank : bst_bank_r;

   always_comb begin
      // blocks wrap on their own boundary; interleave is the xor of start and count
      bst_off = bst_bt_r ? (bst_start_r ^ bst_cnt_r) : (bst_start_r + bst_cnt_r);
      bst_col = (bst_start_r & ~bst_last_r) | (bst_off & bst_last_r);
   end

   always_comb begin
      bst_act_nxt = bst_act_r;
      bst_wr_nxt = bst_wr_r;
      bst_ap_nxt = bst_ap_r;
      bst_bt_nxt = bst_bt_r;
      lat_nxt = lat_r;
      bst_bank_nxt = bst_bank_r;
      bst_start_nxt = bst_start_r;
      bst_cnt_nxt = bst_cnt_r;
      bst_last_nxt = bst_last_r;
      if (lat_r && cke_i) begin
         lat_nxt = 1'b0;
      end
      if (step) begin
         if (last) begin
            bst_act_nxt = 1'b0;
         end else begin
            bst_cnt_nxt = bst_cnt_r + COL_W'(1);
         end
      end
      if (bst_take || (pre_take && (addr_i[AP_BIT] || (cmd_bank == bst_bank_r)))) begin
         bst_act_nxt = 1'b0;
      end
      // a new column command cuts the running burst short
      if (rd_take || wr_take) begin
         bst_bank_nxt = cmd_bank;
         bst_start_nxt = column_address_lines;
         bst_ap_nxt = addr_i[AP_BIT];
         bst_bt_nxt = mode_r[MODE_BT_BIT] && (mode_r[MODE_BL_LSB +: 3] != BL_FULL);
         bst_wr_nxt = wr_take;
         bst_last_nxt = new_last;
         bst_cnt_nxt = wr_take ? COL_W'(1) : COL_W'(0);
         bst_act_nxt = !wr_single;
         lat_nxt = rd_take && (mode_r[MODE_CL_LSB +: 3] == CL_3);
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bst_act_r <= 1'b0;
         bst_wr_r <= 1'b0;
         bst_ap_r <= 1'b0;
         bst_bt_r <= 1'b0;
         lat_r <= 1'b0;
         bst_bank_r <= '0;
         bst_start_r <= '0;
         bst_cnt_r <= '0;
         bst_last_r <= '0;
      end else begin
         bst_act_r <= bst_act_nxt;
         bst_wr_r <= bst_wr_nxt;
         bst_ap_r <= bst_ap_nxt;
         bst_bt_r <= bst_bt_nxt;
         lat_r <= lat_nxt;
         bst_bank_r <= bst_bank_nxt;
         bst_start_r <= bst_start_nxt;
         bst_cnt_r <= bst_cnt_nxt;
         bst_last_r <= bst_last_nxt;
      end
   end

   // =====================================================================
   // per-bank row state and precharge timers
   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      logic open_r;
      logic open_nxt;
      logic [ROW_W-1:0] row_r;
      logic [ROW_W-1:0] row_nxt;
      logic [PRE_W-1:0] pre_r;
      logic [PRE_W-1:0] pre_nxt;
      logic close;

      assign close = (pre_take && (addr_i[AP_BIT] || (cmd_bank == BANK_W'(b))))
                     || (ap_fire && (ap_bank == BANK_W'(b)));

      always_comb begin
         open_nxt = open_r;
         row_nxt = row_r;
         pre_nxt = pre_r;
         if (pre_r != '0) begin
            pre_nxt = pre_r - PRE_W'(1);
         end
         if (act_take && (cmd_bank == BANK_W'(b))) begin
            open_nxt = 1'b1;
            row_nxt = row_address_lines;
         end
         // each bank times its own precharge, so the others keep working
         if (close && open_r) begin
            open_nxt = 1'b0;
            pre_nxt = TRP_CYC;
         end
      end

      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            open_r <= 1'b0;
            row_r <= '0;
            pre_r <= '0;
         end else begin
            open_r <= open_nxt;
            row_r <= row_nxt;
            pre_r <= pre_nxt;
         end
      end

      assign bank_open[b] = open_r;
      assign bank_row[b] = row_r;
      assign bank_pre_busy[b] = (pre_r != '0);
   end

   // =====================================================================
   // storage: one array per 16-bit chip lane
   logic mem_we;
   logic [STORE_AW-1:0] wr_idx;
   logic [STORE_AW-1:0] rd_idx;
   logic [DQ_W-1:0] rd_word;

   // rows and banks fold onto the array when STORE_AW is below the full span
   function automatic logic [STORE_AW-1:0] store_idx(input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] r,
                                                     input logic [COL_W-1:0] c);
      logic [BANK_W+ROW_W+COL_W-1:0] full;
      full = {b, r, c};
      store_idx = full[STORE_AW-1:0];
   endfunction

   assign mem_we = wr_take || (step && bst_wr_r);
   assign wr_idx = wr_take ? store_idx(cmd_bank, bank_row[cmd_bank], column_address_lines)
                           : store_idx(bst_bank_r, bank_row[bst_bank_r], bst_col);
   assign rd_idx = store_idx(bst_bank_r, bank_row[bst_bank_r], bst_col);

   for (genvar c = 0; c < NLANE; c++) begin : g_chip
      logic [LANE_W-1:0] mem [2**STORE_AW];
      always_ff @(posedge clk_i) begin
         if (mem_we && !dqm_i[2*c]) begin
            mem[wr_idx][7:0] <= dq_i[c*LANE_W +: 8];
         end
         if (mem_we && !dqm_i[2*c+1]) begin
            mem[wr_idx][15:8] <= dq_i[c*LANE_W+8 +: 8];
         end
      end
      assign rd_word[c*LANE_W +: LANE_W] = mem[rd_idx];
   end

   // =====================================================================
   // read output path, read mask lags two cycles like the data at latency two (data lags three at latency three)
   logic buf_out_valid;
   logic [DQM_W-1:0] dqm_d1_r;
   logic [DQM_W-1:0] dqm_d2_r;
   logic pwr_down_r;
   logic pwr_down_nxt;

   out_buf #(.W(DQ_W)) u_out_buf (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(buf_in_valid),
      .in_ready_o(buf_in_ready),
      .in_data_i(rd_word),
      .out_valid_o(buf_out_valid),
      .out_ready_i(cke_i),
      .out_data_o(dq_o)
   );

   assign pwr_down_nxt = !cke_i && !bst_act_r && !buf_out_valid;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dqm_d1_r <= '1;
         dqm_d2_r <= '1;
         pwr_down_r <= 1'b0;
      end else begin
         dqm_d1_r <= dqm_i;
         dqm_d2_r <= dqm_d1_r;
         pwr_down_r <= pwr_down_nxt;
      end
   end

   assign dq_oe_o = buf_out_valid ? ~dqm_d2_r : '0;

   // =====================================================================
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_act_row: assert property (act_take |=> bank_open[$past(cmd_bank)]
      && bank_row[$past(cmd_bank)] == $past(row_address_lines))
      else $error("activation did not open the addressed row");
   chk_rd_needs_act: assert property ((cmd == CMD_RD && !bank_open[cmd_bank] && !bst_act_r)
      |=> !bst_act_r)
      else $error("read started on a closed bank");
   chk_col_start: assert property ((rd_take || wr_take) |=> bst_start_r == $past(column_address_lines))
      else $error("burst start column not captured");
   chk_read_latency: assert property ((rd_take && mode_r[MODE_CL_LSB +: 3] == CL_3)
      |=> !buf_in_valid ##1 (buf_in_valid || !cke_i))
      else $error("read data not aligned to latency three");
   chk_burst_bound: assert property (bst_act_r |-> bst_cnt_r <= bst_last_r)
      else $error("burst counter ran past burst length");
   chk_burst_stop: assert property ((step && last && !rd_take && !wr_take) |=> !bst_act_r)
      else $error("burst did not end at its length");
   chk_auto_pre: assert property ((step && last && bst_ap_r)
      |=> !bank_open[$past(bst_bank_r)] && bank_pre_busy[$past(bst_bank_r)])
      else $error("auto precharge did not close the bank");
   chk_random_col: assert property (rd_take ##1 rd_take |=> bst_cnt_r == '0 && bst_act_r)
      else $error("back to back column command not taken");
   chk_hidden_pre: assert property ((cmd == CMD_ACT && init_r == IS_READY && !bank_open[cmd_bank]
      && !bank_pre_busy[cmd_bank] && (bank_pre_busy != '0)) |=> bank_open[$past(cmd_bank)])
      else $error("activation blocked by another bank precharging");
   chk_refresh_row: assert property (ref_take |=> ref_row_r == $past(ref_row_r) + ROW_W'(1))
      else $error("auto refresh did not advance the row counter");
   chk_suspend: assert property ((bst_act_r && !cke_i) |=> $stable(bst_cnt_r) && !pwr_down_r)
      else $error("burst moved while clock enable was low");

   cov_read_burst: cover property (rd_take ##[1:12] (step && last));
   cov_auto_pre: cover property (ap_fire);
   cov_mode_load: cover property (lmr_take ##1 init_r == IS_READY);
   cov_power_down: cover property (pwr_down_r [*3]);

endmodule

// ### tb/ctrl_model.sv
// controller model driving the command, address and write data pins
module ctrl_model
   import sdram_pkg::*;
(
   input wire logic clk_i,                  // system clock
   output logic cke_o,                      // clock enable
   output logic cs_n_o,                     // chip select, active low
   output logic [2:0] cmd_o,                // {ras_n, cas_n, we_n}
   output logic [BANK_W-1:0] bank_o,        // bank select pair
   output logic [ROW_W-1:0] addr_o,         // address lines
   output logic [DQ_W-1:0] dq_drv_o         // write data lines
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================================================
   // command issue at the falling edge
   initial begin
      cke_o = 1'b1;
      cs_n_o = 1'b1;
      cmd_o = CMD_NOP;
      bank_o = '0;
      addr_o = '0;
      dq_drv_o = '0;
   end
   // released data lines flip so a stale word never looks valid
   task automatic cmd(input logic [2:0] c, input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] a,
                      input logic [DQ_W-1:0] d);
      @(negedge clk_i);
      cs_n_o = 1'b0;
      cmd_o = c;
      bank_o = b;
      addr_o = a;
      dq_drv_o = (c == CMD_WR) ? d : ~dq_drv_o;
   endtask
   task automatic data(input logic [DQ_W-1:0] d);
      @(negedge clk_i);
      cmd_o = CMD_NOP;
      dq_drv_o = d;
   endtask
   // nop only through the settle wait, then precharge all, two refreshes, mode load
   task automatic init(input int cyc, input logic [ROW_W-1:0] mode);
      repeat (cyc) cmd(CMD_NOP, '0, '0, '0);
      cmd(CMD_PRE, '0, 13'h0400, '0);
      cmd(CMD_REF, '0, '0, '0);
      cmd(CMD_REF, '0, '0, '0);
      cmd(CMD_LMR, '0, mode, '0);
      repeat (2) cmd(CMD_NOP, '0, '0, '0);
   endtask
endmodule

// ### tb/sdram_access_and_init_tb_top.sv
// self-checking bench for the dram module core
module sdram_access_and_init_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sdram_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cke, cs_n;
   logic [2:0] cmd;
   logic [BANK_W-1:0] bank;
   logic [ROW_W-1:0] addr;
   logic [DQ_W-1:0] dq_w, dq_o;
   logic [DQM_W-1:0] dq_oe_o;
   int fail_count = 0;
   int tests_run = 0;
   always #10 clk_i = ~clk_i;
   ctrl_model cu (.clk_i(clk_i), .cke_o(cke), .cs_n_o(cs_n), .cmd_o(cmd), .bank_o(bank), .addr_o(addr),
                  .dq_drv_o(dq_w));
   sdram_core #(.PWRUP_CYCLES(10)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cke_i(cke), .cs_n_i(cs_n),
      .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]), .bank_select_low_i(bank[0]),
      .bank_select_high_i(bank[1]), .addr_i(addr), .dqm_i(8'h00), .dq_i(dq_w), .dq_o(dq_o), .dq_oe_o(dq_oe_o));
   // =====================================================================
   // helpers
   // distinct lanes expose a swapped chip lane
   function automatic logic [DQ_W-1:0] pat(input logic [COL_W-1:0] c);
      return {6'h33, c, 6'h22, c, 6'h11, c, 6'h00, c};
   endfunction
   task automatic chk(input string what, input logic [DQ_W-1:0] exp, input logic [DQ_W-1:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [1:0] b, input logic [COL_W-1:0] s[4]);
      cu.cmd(CMD_WR, b, {3'h0, s[0]}, pat(s[0]));
      for (int i = 1; i < 4; i++) cu.data(pat(s[i]));
      cu.cmd(CMD_NOP, '0, '0, '0);
   endtask
   // n words expected in order s, none when the read must be refused
   task automatic rd(input logic [1:0] b, input logic ap, input logic [COL_W-1:0] s[4], input int n,
                     input int cl = 2);
      cu.cmd(CMD_RD, b, {2'h0, ap, s[0]}, '0);
      cu.cmd(CMD_NOP, '0, '0, '0);
      // latency three: pins stay released one cycle longer
      if (cl == 3) begin
         @(negedge clk_i);
         chk("dq_oe_o early", 64'h0, 64'(dq_oe_o));
      end
      for (int i = 0; i < n; i++) begin
         @(negedge clk_i);
         chk("dq_o", pat(s[i]), dq_o);
         chk("dq_oe_o", 64'hff, 64'(dq_oe_o));
      end
      @(negedge clk_i);
      chk("dq_oe_o idle", 64'h0, 64'(dq_oe_o));
   endtask
   // =====================================================================
   // scenarios
   task automatic t_init();
      repeat (2) @(posedge clk_i);
      @(negedge clk_i) sys_rst_i = 1'b0;
      cu.init(12, 13'h0022);
      rd(2'h0, 1'b0, '{10'h1, 10'h2, 10'h3, 10'h0}, 0);
      $display("init done");
   endtask
   task automatic t_wr_rd();
      cu.cmd(CMD_ACT, 2'h0, 13'h0000, '0);
      wr(2'h0, '{10'h1, 10'h2, 10'h3, 10'h0});
      rd(2'h0, 1'b0, '{10'h1, 10'h2, 10'h3, 10'h0}, 4);
      rd(2'h0, 1'b0, '{10'h2, 10'h3, 10'h0, 10'h1}, 4);
      $display("write read done");
   endtask
   task automatic t_b2b();
      cu.cmd(CMD_RD, 2'h0, 13'h0000, '0);
      rd(2'h0, 1'b0, '{10'h2, 10'h3, 10'h0, 10'h1}, 4);
      $display("back to back done");
   endtask
   task automatic t_bank();
      cu.cmd(CMD_ACT, 2'h1, 13'h0000, '0);
      wr(2'h1, '{10'h8, 10'h9, 10'ha, 10'hb});
      cu.cmd(CMD_PRE, 2'h0, 13'h0000, '0);
      rd(2'h1, 1'b0, '{10'h8, 10'h9, 10'ha, 10'hb}, 4);
      rd(2'h0, 1'b0, '{10'h1, 10'h2, 10'h3, 10'h0}, 0);
      $display("bank overlap done");
   endtask
   task automatic t_ap();
      rd(2'h1, 1'b1, '{10'h9, 10'ha, 10'hb, 10'h8}, 4);
      repeat (3) cu.cmd(CMD_NOP, '0, '0, '0);
      rd(2'h1, 1'b0, '{10'h9, 10'ha, 10'hb, 10'h8}, 0);
      cu.cmd(CMD_ACT, 2'h1, 13'h0000, '0);
      rd(2'h1, 1'b0, '{10'ha, 10'hb, 10'h8, 10'h9}, 4);
      $display("auto precharge done");
   endtask
   // clock enable low freezes the burst and holds the output word
   task automatic t_stall();
      cu.cmd(CMD_ACT, 2'h0, 13'h0000, '0);
      cu.cmd(CMD_RD, 2'h0, 13'h0001, '0);
      cu.cmd(CMD_NOP, '0, '0, '0);
      @(negedge clk_i) cu.cke_o = 1'b0;
      chk("dq_o", pat(10'h1), dq_o);
      repeat (3) @(negedge clk_i) chk("dq_o held", pat(10'h1), dq_o);
      cu.cke_o = 1'b1;
      @(negedge clk_i) chk("dq_o resumed", pat(10'h2), dq_o);
      repeat (4) @(negedge clk_i);
      // idle with clock enable low enters power-down; pins must stay released
      cu.cke_o = 1'b0;
      repeat (4) @(negedge clk_i);
      chk("dq_oe_o power down", 64'h0, 64'(dq_oe_o));
      cu.cke_o = 1'b1;
      $display("power down stall done");
   endtask
   // activate during another bank's precharge, then reload mode: interleave, length 4, latency 3
   task automatic t_mode();
      cu.cmd(CMD_PRE, 2'h1, 13'h0000, '0);
      cu.cmd(CMD_ACT, 2'h3, 13'h0000, '0);
      cu.cmd(CMD_PRE, 2'h0, 13'h0400, '0);
      cu.cmd(CMD_NOP, '0, '0, '0);
      cu.cmd(CMD_LMR, '0, 13'h003a, '0);
      repeat (2) cu.cmd(CMD_NOP, '0, '0, '0);
      cu.cmd(CMD_ACT, 2'h0, 13'h0000, '0);
      rd(2'h0, 1'b0, '{10'h9, 10'h8, 10'hb, 10'ha}, 4, 3);
      $display("mode reload done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      fail_count++;
      print_verdict();
   end
   initial begin
      t_init();
      t_wr_rd();
      t_b2b();
      t_bank();
      t_ap();
      t_stall();
      t_mode();
      print_verdict();
   end
endmodule
